// File: rtl/scpc_pkg.sv
/*
 * Package for the serial control port clocking block: constants and carrier structs.
 * Assumes one 200 MHz system clock; the serial link is sampled, not a clock domain.
 */
package scpc_pkg;

  // ----------------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------------
  localparam int unsigned BITS_PER_ACCESS = 8;
  localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;
  localparam logic [7:0]  SHIFT_RESET     = 8'h00;
  localparam int unsigned MSB_POS         = 7;

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [2:0]  SYNC_RESET  = 3'h0;

  // Pins of the serial port as seen by the device
  typedef struct packed {
    logic clk;
    logic sel_n;
    logic din;
  } scpc_pins_t;

  // Parallel side of the port
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } scpc_byte_t;

  typedef enum logic [1:0] {
    SCPC_IDLE  = 2'b00,
    SCPC_SHIFT = 2'b01,
    SCPC_DONE  = 2'b10
  } scpc_state_t;

endpackage

// File: rtl/scpc_port.sv
/*
 * Device end of the byte-wide serial control port: clock edge detection,
 * bit capture, bit launch, output and interrupt release.
 * Assumes the master keeps select low across all eight clock pulses.
 */
`timescale 1ns/100ps
// Overview of operation
// - Normal format: clock idles low, 8 pulses
// - Alternate format: clock idles high, 8 pulses
// - Output bit changes on falling clock edges
// - Input bit captured on rising clock edges
// - Output high impedance while select high
// - Interrupt released while select low
module scpc_port
  import scpc_pkg::*;
(
  input  wire logic       MCLK_IN,
  input  wire logic       RSTN_IN,
  input  wire logic       SERIAL_CTRL_CLOCK_IN,
  input  wire logic       SERIAL_CTRL_SEL_N_IN,
  input  wire logic       SERIAL_CTRL_IN_IN,
  input  wire logic [7:0] TX_DATA_IN,
  input  wire logic       INT_REQ_IN,
  output logic            SERIAL_CTRL_OUT_OUT,
  output logic            SERIAL_CTRL_OUT_OE_OUT,
  output logic            INT_N_OUT,
  output logic            INT_N_OE_OUT,
  output logic            RX_VALID_OUT,
  output logic [7:0]      RX_DATA_OUT,
  output logic            ALT_FORMAT_OUT
);

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  wire scpc_pins_t pins;

  scpc_sync u_sync_clk (
    .clk_in         (MCLK_IN),
    .rst_n_in       (RSTN_IN),
    .pin_in         (SERIAL_CTRL_CLOCK_IN),
    .reset_level_in (1'b0),
    .level_out      (pins.clk)
  );

  scpc_sync u_sync_sel (
    .clk_in         (MCLK_IN),
    .rst_n_in       (RSTN_IN),
    .pin_in         (SERIAL_CTRL_SEL_N_IN),
    .reset_level_in (1'b1),
    .level_out      (pins.sel_n)
  );

  scpc_sync u_sync_din (
    .clk_in         (MCLK_IN),
    .rst_n_in       (RSTN_IN),
    .pin_in         (SERIAL_CTRL_IN_IN),
    .reset_level_in (1'b1),
    .level_out      (pins.din)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    scpc_state_t state;
    logic        clk_prev;
    logic        alt_fmt;
    logic [3:0]  rise_cnt;
    logic [7:0]  rx_shift;
    logic [7:0]  tx_shift;
    logic        dout;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        int_pend;
  } scpc_port_t;

  scpc_port_t st_reg;
  scpc_port_t st_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Edge towards a level between two samples of the filtered clock
  function automatic logic edge_to(input logic now_lvl,
                                   input logic prev_lvl,
                                   input logic to_lvl);
    return (now_lvl == to_lvl) && (prev_lvl != to_lvl);
  endfunction

  // Receive shifter, MSB first; also forms the finished byte
  function automatic logic [7:0] shift_in(input logic [7:0] word,
                                          input logic       bit_in);
    return {word[6:0], bit_in};
  endfunction

  logic rise;
  logic fall;
  logic sel_edge;

  assign rise     = edge_to(pins.clk, st_reg.clk_prev, 1'b1);
  assign fall     = edge_to(pins.clk, st_reg.clk_prev, 1'b0);
  // Select seen low while waiting for an access
  assign sel_edge = (st_reg.state == SCPC_IDLE) & ~pins.sel_n;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.clk_prev = pins.clk;
    st_next.rx_valid = 1'b0;
    st_next.int_pend = INT_REQ_IN;
    unique case (st_reg.state)
      SCPC_IDLE: begin
        // Idle clock level picks the format; both accepted
        st_next.alt_fmt = pins.clk;
        if (sel_edge) begin
          st_next.state    = SCPC_SHIFT;
          st_next.rise_cnt = BIT_CNT_RESET;
          st_next.tx_shift = TX_DATA_IN;
          // First bit is valid straight after select falls
          st_next.dout     = TX_DATA_IN[MSB_POS];
        end
      end
      SCPC_SHIFT: begin
        if (pins.sel_n) begin
          st_next.state = SCPC_IDLE;
        end else begin
          // In alternate format the leading fall is idle-exit, not a launch
          if (fall && (st_reg.rise_cnt != BIT_CNT_RESET)) begin
            st_next.dout = st_reg.tx_shift[MSB_POS];
          end
          if (rise) begin
            st_next.rx_shift = shift_in(st_reg.rx_shift, pins.din);
            st_next.tx_shift = {st_reg.tx_shift[6:0], 1'b0};
            st_next.rise_cnt = st_reg.rise_cnt + 4'h1;
            if (st_reg.rise_cnt == 4'(BITS_PER_ACCESS - 1)) begin
              st_next.rx_valid = 1'b1;
              st_next.rx_data  = shift_in(st_reg.rx_shift, pins.din);
              st_next.state    = SCPC_DONE;
            end
          end
        end
      end
      SCPC_DONE: begin
        // Extra pulses after the eighth are ignored until select rises
        if (pins.sel_n) begin
          st_next.state = SCPC_IDLE;
        end
      end
      default: begin
        st_next.state = SCPC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Clock history resets low, matching the filtered clock's reset level
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_reg <= '{state:    SCPC_IDLE,
                  clk_prev: 1'b0,
                  alt_fmt:  1'b0,
                  rise_cnt: BIT_CNT_RESET,
                  rx_shift: SHIFT_RESET,
                  tx_shift: SHIFT_RESET,
                  dout:     1'b0,
                  rx_valid: 1'b0,
                  rx_data:  SHIFT_RESET,
                  int_pend: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  assign SERIAL_CTRL_OUT_OUT    = st_reg.dout;
  assign SERIAL_CTRL_OUT_OE_OUT = ~pins.sel_n;
  // Open drain: drives low only while pending and select high
  assign INT_N_OUT              = 1'b0;
  assign INT_N_OE_OUT           = st_reg.int_pend & pins.sel_n;
  assign RX_VALID_OUT           = st_reg.rx_valid;
  assign RX_DATA_OUT            = st_reg.rx_data;
  assign ALT_FORMAT_OUT         = st_reg.alt_fmt;

endmodule

// File: rtl/scpc_sync.sv
/*
 * Three-stage pin synchroniser; a change counts when stages two and three agree.
 * Assumes the input is asynchronous to clk_in.
 */
`timescale 1ns/100ps
module scpc_sync
  import scpc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  input  wire logic reset_level_in,
  output logic      level_out
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } scpc_sync_t;

  scpc_sync_t st_reg;
  scpc_sync_t st_next;

  always_comb begin
    st_next       = st_reg;
    // Held relative to the reset level, so reset loads constants only
    st_next.stage = {st_reg.stage[1:0], pin_in ^ reset_level_in};
    // Stage 0 is read only by stage 1; filter looks at 1 and 2
    if (st_reg.stage[1] == st_reg.stage[2]) begin
      st_next.level = st_reg.stage[2];
    end
  end

  // All zero means "at the reset level"; no false change after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '{stage: SYNC_RESET, level: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level ^ reset_level_in;

endmodule

// File: sim/scpc_host.sv
/* Serial master model: one eight pulse access in either clock format.
   Assumes miso_in is the resolved data line. */
`timescale 1ns/100ps
module scpc_host (
  output logic      sclk_out,
  output logic      sel_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Bit set on the fall, read back on the rise; 64 ns period
  task automatic xfer(input logic alt, input logic [7:0] tx, output logic [7:0] rx);
    // Half a step off keeps link edges clear of system clock edges
    #0.5;
    sclk_out = alt;
    #200 sel_n_out = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      sclk_out = 1'b0;
      mosi_out = tx[i];
      #32 sclk_out = 1'b1;
      rx[i] = miso_in;
      #32;
    end
    sclk_out = alt;
    #100 sel_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule

// File: sim/scpc_port_properties.sv
/* Timing checks on the serial port pins of scpc_port.
   Assumes the master spaces clock edges at least 6 system clocks apart. */
`timescale 1ns/100ps
module scpc_port_properties
  import scpc_pkg::*;
(
  input wire logic       MCLK_IN,
  input wire logic       RSTN_IN,
  input wire logic       SERIAL_CTRL_CLOCK_IN,
  input wire logic       SERIAL_CTRL_SEL_N_IN,
  input wire logic       INT_REQ_IN,
  input wire logic       SERIAL_CTRL_OUT_OUT,
  input wire logic       SERIAL_CTRL_OUT_OE_OUT,
  input wire logic       INT_N_OE_OUT,
  input wire logic       RX_VALID_OUT,
  input wire logic [7:0] RX_DATA_OUT,
  input wire logic       ALT_FORMAT_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  property p_oe_off; $rose(SERIAL_CTRL_SEL_N_IN) |-> ##[1:6] !SERIAL_CTRL_OUT_OE_OUT; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out still driven");
  property p_oe_on; $fell(SERIAL_CTRL_SEL_N_IN) |-> ##[1:6] SERIAL_CTRL_OUT_OE_OUT; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data out not driven");
  property p_int_rel; !SERIAL_CTRL_SEL_N_IN [*7] |-> !INT_N_OE_OUT; endproperty
  a_int_rel: assert property (p_int_rel) else $error("interrupt not released");
  property p_int_set; (INT_REQ_IN && SERIAL_CTRL_SEL_N_IN) [*7] |-> INT_N_OE_OUT; endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not driven");
  // Shift lands only after a falling edge, so output holds after a rise
  property p_out_hold; $rose(SERIAL_CTRL_CLOCK_IN) |=> $stable(SERIAL_CTRL_OUT_OUT) [*5]; endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved on rise");
  property p_vld; RX_VALID_OUT |=> !RX_VALID_OUT; endproperty
  a_vld: assert property (p_vld) else $error("valid longer than one cycle");
  property p_data_hold; $rose(RX_VALID_OUT) |=> $stable(RX_DATA_OUT) [*8]; endproperty
  a_data_hold: assert property (p_data_hold) else $error("received byte moved");
  property p_alt_hold; !SERIAL_CTRL_SEL_N_IN [*8] |=> $stable(ALT_FORMAT_OUT); endproperty
  a_alt_hold: assert property (p_alt_hold) else $error("format flipped in access");
endmodule
bind scpc_port scpc_port_properties scpc_port_properties_inst (.MCLK_IN, .RSTN_IN,
  .SERIAL_CTRL_CLOCK_IN, .SERIAL_CTRL_SEL_N_IN, .INT_REQ_IN, .SERIAL_CTRL_OUT_OUT,
  .SERIAL_CTRL_OUT_OE_OUT, .INT_N_OE_OUT, .RX_VALID_OUT, .RX_DATA_OUT, .ALT_FORMAT_OUT);

// File: sim/test_scpc_port.sv
/* Self-checking bench for scpc_port with a serial master model.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/100ps
module test_scpc_port
  import scpc_pkg::*;
;
  logic MCLK_IN = 1'b0, RSTN_IN = 1'b0, INT_REQ_IN = 1'b0;
  logic SERIAL_CTRL_CLOCK_IN, SERIAL_CTRL_SEL_N_IN, SERIAL_CTRL_IN_IN, miso;
  logic SERIAL_CTRL_OUT_OUT, SERIAL_CTRL_OUT_OE_OUT, INT_N_OUT, INT_N_OE_OUT;
  logic RX_VALID_OUT, ALT_FORMAT_OUT, miso_last = 1'b0;
  logic [7:0] TX_DATA_IN = 8'h00, RX_DATA_OUT, n_valid = 8'h00;
  int mismatches = 0, n_checks = 0, cycles = 0;
  scpc_port scpc_port_inst (.MCLK_IN, .RSTN_IN, .SERIAL_CTRL_CLOCK_IN, .SERIAL_CTRL_SEL_N_IN,
    .SERIAL_CTRL_IN_IN, .TX_DATA_IN, .INT_REQ_IN, .SERIAL_CTRL_OUT_OUT, .SERIAL_CTRL_OUT_OE_OUT,
    .INT_N_OUT, .INT_N_OE_OUT, .RX_VALID_OUT, .RX_DATA_OUT, .ALT_FORMAT_OUT);
  scpc_host scpc_host_inst (.sclk_out(SERIAL_CTRL_CLOCK_IN), .sel_n_out(SERIAL_CTRL_SEL_N_IN),
    .mosi_out(SERIAL_CTRL_IN_IN), .miso_in(miso));
  // Released line shows the inverse, so a stale bit cannot pass
  assign miso = SERIAL_CTRL_OUT_OE_OUT ? SERIAL_CTRL_OUT_OUT : ~miso_last;
  always #2.5 MCLK_IN = ~MCLK_IN;
  always @(posedge MCLK_IN) begin
    if (SERIAL_CTRL_OUT_OE_OUT) miso_last <= SERIAL_CTRL_OUT_OUT;
    if (RX_VALID_OUT === 1'b1) n_valid <= n_valid + 8'h01;
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic t_formats();
    logic [7:0] rx;
    logic [7:0] base;
    logic [7:0] pat [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK_IN);
      #1 TX_DATA_IN = ~pat[i];
      base = n_valid;
      scpc_host_inst.xfer(i[0], pat[i], rx);
      check("out_byte", rx, ~pat[i]);
      check("in_byte", RX_DATA_OUT, pat[i]);
      check("valid_count", n_valid - base, 8'h01);
      check("alt_format", ALT_FORMAT_OUT, i[0]);
      check("out_oe_idle", SERIAL_CTRL_OUT_OE_OUT, 1'b0);
    end
  endtask
  task automatic t_interrupt();
    logic [7:0] rx;
    @(posedge MCLK_IN);
    #1 INT_REQ_IN = 1'b1;
    repeat (10) @(posedge MCLK_IN);
    #1;
    check("int_oe_idle", INT_N_OE_OUT, 1'b1);
    check("int_level", INT_N_OUT, 1'b0);
    fork
      scpc_host_inst.xfer(1'b0, 8'h5a, rx);
      #400 check("int_oe_sel", INT_N_OE_OUT, 1'b0);
    join
    check("int_oe_after", INT_N_OE_OUT, 1'b1);
    check("in_byte_int", RX_DATA_OUT, 8'h5a);
    check("out_byte_int", rx, 8'h81);
    @(posedge MCLK_IN);
    #1 INT_REQ_IN = 1'b0;
  endtask
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge MCLK_IN);
    #1 RSTN_IN = 1'b1;
    t_formats();
    t_interrupt();
    final_report();
  end
endmodule
